//--- logic/iora_pkg.sv
/*
 * Shared constants and types for the I/O register allocator: word spaces,
 * module type codes, link block settings and engine states.
 * Assumes every user refers to names as iora_pkg::name, with no import.
 */
package iora_pkg;

	// Word spaces and geometry
	localparam int IORA_IO_WORDS = 1024;
	localparam int IORA_SCAN_WORDS = 1024;
	localparam int IORA_BLOCK_WORDS = 64;
	localparam int IORA_CHANNELS = 2;
	localparam int IORA_UNITS = 4;
	localparam int IORA_SLOTS = 11;
	localparam int IORA_HALF_SLOTS = 6;
	localparam int IORA_DATA_W = 16;
	localparam int IORA_TYPE_W = 4;
	localparam int IORA_WEXP_W = 3;
	localparam int IORA_CNT_W = 8;
	localparam int IORA_MODE_W = 2;

	// Legal word count exponents per function class
	localparam logic [2:0] IORA_SINGLE_MAX_EXP = 3'h5;
	localparam logic [2:0] IORA_MIXED_MIN_EXP = 3'h1;
	localparam logic [2:0] IORA_MIXED_MAX_EXP = 3'h7;
	localparam logic [2:0] IORA_Z_MIN_EXP = 3'h3;
	localparam logic [2:0] IORA_Z_MAX_EXP = 3'h5;

	// Error flag bit positions
	localparam int IORA_ERR_W = 3;
	localparam int IORA_ERR_BASE_LOW = 0;
	localparam int IORA_ERR_OVERFLOW = 1;
	localparam int IORA_ERR_BAD_TYPE = 2;

	// Slot module type codes
	typedef enum logic [3:0] {
		iora_none = 4'h0,
		iora_input = 4'h1,
		iora_output = 4'h2,
		iora_mixed = 4'h3,
		iora_nonbatch_input_type = 4'h4,
		iora_nonbatch_output_type = 4'h5,
		iora_nonbatch_mixed_type = 4'h6,
		iora_unused_z_type = 4'h7,
		iora_spacer_slot_type = 4'h8,
		iora_memory_card_slot_type = 4'h9,
		iora_scan_network_slot_type = 4'ha,
		iora_fast_network_slot_type = 4'hb
	} iora_slot_t;

	// Link register block settings
	typedef enum logic [1:0] {
		iora_blk_blank = 2'h0,
		iora_blk_link = 2'h1,
		iora_blk_bridge = 2'h2
	} iora_blk_t;

	// Allocation engine states
	typedef enum logic [6:0] {
		iora_a_idle = 7'h01,
		iora_a_unit = 7'h02,
		iora_a_slot = 7'h04,
		iora_a_word = 7'h08,
		iora_a_next = 7'h10,
		iora_a_done = 7'h20,
		iora_a_err = 7'h40
	} iora_alloc_t;

	// Link transfer states
	typedef enum logic [1:0] {
		iora_x_idle = 2'h1,
		iora_x_read = 2'h2
	} iora_xfer_t;

endpackage : iora_pkg

//--- logic/iora_slot_cost.sv
/*
 * Combinational decoder from a slot's module type and word count exponent
 * to the input and output words it occupies, plus a legality flag.
 * Assumes the caller masks slots that are not configured to type none.
 */
`timescale 1ns/10ps
module iora_slot_cost (
	input wire iora_pkg::iora_slot_t slot_type,
	input wire logic [2:0] wexp,
	output logic [7:0] in_cnt,
	output logic [7:0] out_cnt,
	output logic legal
);

	logic [7:0] words;
	logic single_ok;
	logic mixed_ok;

	// Word count is a power of two from the exponent
	assign words = 8'h01 << wexp;
	assign single_ok = (wexp <= iora_pkg::IORA_SINGLE_MAX_EXP);
	assign mixed_ok = (wexp >= iora_pkg::IORA_MIXED_MIN_EXP) &&
		(wexp <= iora_pkg::IORA_MIXED_MAX_EXP);

	// Class decode; mixed modules split words evenly, inputs first
	always_comb begin
		in_cnt = 8'h00;
		out_cnt = 8'h00;
		legal = 1'b1;
		case (slot_type)
			iora_pkg::iora_none: legal = 1'b1;
			iora_pkg::iora_input, iora_pkg::iora_nonbatch_input_type: begin
				in_cnt = words;
				legal = single_ok;
			end
			iora_pkg::iora_output, iora_pkg::iora_nonbatch_output_type: begin
				out_cnt = words;
				legal = single_ok;
			end
			iora_pkg::iora_mixed, iora_pkg::iora_nonbatch_mixed_type: begin
				in_cnt = words >> 1;
				out_cnt = words >> 1;
				legal = mixed_ok;
			end
			iora_pkg::iora_spacer_slot_type: out_cnt = words;
			iora_pkg::iora_unused_z_type: begin
				legal = (wexp >= iora_pkg::IORA_Z_MIN_EXP) &&
					(wexp <= iora_pkg::IORA_Z_MAX_EXP);
			end
			iora_pkg::iora_memory_card_slot_type,
			iora_pkg::iora_scan_network_slot_type,
			iora_pkg::iora_fast_network_slot_type: legal = 1'b1;
			default: legal = 1'b0;
		endcase
	end

endmodule : iora_slot_cost

//--- logic/iora_scan_mem.sv
/*
 * Scan data memory of one network channel: a controller port and a
 * network port, each with write enable and registered read data.
 * Assumes both ports run on sys_clk; the controller wins a same-word write.
 */
`timescale 1ns/10ps
module iora_scan_mem #(
	parameter int DEPTH = iora_pkg::IORA_SCAN_WORDS,
	parameter int DW = iora_pkg::IORA_DATA_W
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic ctl_we,
	input wire logic [$clog2(DEPTH)-1:0] ctl_addr,
	input wire logic [DW-1:0] ctl_wdata,
	output logic [DW-1:0] ctl_rdata,
	input wire logic net_we,
	input wire logic [$clog2(DEPTH)-1:0] net_addr,
	input wire logic [DW-1:0] net_wdata,
	output logic [DW-1:0] net_rdata
);

	logic [DW-1:0] mem [DEPTH];

	// Word-addressed storage, controller has priority on a clash
	always_ff @(posedge sys_clk) begin
		if (ctl_we) begin
			mem[ctl_addr] <= ctl_wdata;
		end
		if (net_we && !(ctl_we && (net_addr == ctl_addr))) begin
			mem[net_addr] <= net_wdata;
		end
	end

	// Registered read ports
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_rdata <= '0;
			net_rdata <= '0;
		end else begin
			ctl_rdata <= mem[ctl_addr];
			net_rdata <= mem[net_addr];
		end
	end

endmodule : iora_scan_mem

//--- logic/iora_allocator.sv
/*
 * I/O register allocator: walks units and slots to place each module's
 * input and output words, and moves link registers to and from the scan
 * memories of up to two network channels by 64-word block settings.
 * Assumes configuration is held stable by the programming tool meanwhile.
 */
// Summary of operation
// - Manual unit base places first register there
// - Base below used addresses is rejected
// - Addresses ascend slot by slot, left first
// - Unset base continues after previous unit
// - Unconfigured slot takes no addresses
// - Half rack trailing slots take none
// - Spacer reserves output words by count
// - Z, memory, network types take none
// - Unallocated words read as output words
// - Each channel has 1024-word scan memory
// - Link blocks of 64 words, one setting
// - Direction per word from send range
// - Blank block makes no transfer
// - Link block accesses channel scan memory
// - Bridge only with two channels fitted
// - Two channels; nearer one is channel_one
// - Bridge reads receiver, copies to sender
// - Word counts 1..32, mixed up to 128
`timescale 1ns/10ps
module iora_allocator #(
	parameter int NU = iora_pkg::IORA_UNITS,
	parameter int NS = iora_pkg::IORA_SLOTS,
	parameter int HALF_SLOTS = iora_pkg::IORA_HALF_SLOTS,
	parameter int AW = 10,
	parameter int DW = iora_pkg::IORA_DATA_W
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic alloc_start,
	input wire logic alloc_auto,
	input wire logic [NU-1:0] unit_base_set,
	input wire logic [NU*AW-1:0] unit_base,
	input wire logic [NU-1:0] half_rack,
	input wire logic [NU*NS*4-1:0] slot_type,
	input wire logic [NU*NS*3-1:0] slot_wexp,
	output logic alloc_busy,
	output logic alloc_done,
	output logic [iora_pkg::IORA_ERR_W-1:0] alloc_error,
	output logic [$clog2(NU*NS)-1:0] alloc_err_slot,
	input wire logic [$clog2(NU*NS)-1:0] qry_slot,
	output logic [AW-1:0] qry_first,
	output logic [7:0] qry_in_cnt,
	output logic [7:0] qry_out_cnt,
	input wire logic [AW-1:0] word_addr,
	output logic word_is_input,
	input wire logic [1:0] chan_fitted,
	input wire logic [31:0] blk_mode_ch1,
	input wire logic [31:0] blk_mode_ch2,
	input wire logic [9:0] send_lo_ch1,
	input wire logic [9:0] send_hi_ch1,
	input wire logic [9:0] send_lo_ch2,
	input wire logic [9:0] send_hi_ch2,
	input wire logic xfer_req,
	input wire logic [9:0] xfer_addr,
	input wire logic [DW-1:0] xfer_wdata,
	output logic xfer_ready,
	output logic xfer_done,
	output logic xfer_rd_valid,
	output logic [DW-1:0] xfer_rdata,
	output logic xfer_cfg_err,
	input wire logic [1:0] net_we,
	input wire logic [19:0] net_addr,
	input wire logic [2*DW-1:0] net_wdata,
	output logic [2*DW-1:0] net_rdata
);

	localparam int UW = (NU > 1) ? $clog2(NU) : 1;
	localparam int SW = $clog2(NS);
	localparam int IW = $clog2(NU*NS);
	localparam int NSLOT = NU*NS;
	localparam int BLK_W = $clog2(iora_pkg::IORA_SCAN_WORDS / iora_pkg::IORA_BLOCK_WORDS);

	// Elaboration checks on geometry
	if ((1 << AW) != iora_pkg::IORA_IO_WORDS) begin : g_chk_aw
		$error("AW must match the I/O word space");
	end
	if (HALF_SLOTS > NS || NS < 2) begin : g_chk_slots
		$error("slot geometry unsupported");
	end

	iora_pkg::iora_alloc_t as_reg;
	logic [UW-1:0] unit_reg;
	logic [SW-1:0] slot_reg;
	logic [AW:0] next_addr_reg;
	logic [7:0] word_cnt_reg;
	logic [7:0] total_reg;
	logic [7:0] in_cnt_reg;
	iora_pkg::iora_slot_t cur_type_reg;
	logic [iora_pkg::IORA_IO_WORDS-1:0] in_map_reg;
	logic [AW-1:0] first_mem [NSLOT];
	logic [7:0] inc_mem [NSLOT];
	logic [7:0] outc_mem [NSLOT];
	logic [IW-1:0] idx;
	iora_pkg::iora_slot_t eff_type;
	logic [2:0] eff_wexp;
	logic [7:0] cost_in;
	logic [7:0] cost_out;
	logic [7:0] cost_total;
	logic cost_legal;
	logic [AW-1:0] base_val;
	logic base_used;
	logic base_low;
	logic [AW+1:0] slot_end;

	// Current slot select and half rack masking
	assign idx = IW'(int'(unit_reg) * NS + int'(slot_reg));
	assign eff_type = (half_rack[unit_reg] && (int'(slot_reg) >= HALF_SLOTS)) ?
		iora_pkg::iora_none : iora_pkg::iora_slot_t'(slot_type[int'(idx)*4 +: 4]);
	assign eff_wexp = slot_wexp[int'(idx)*3 +: 3];
	assign base_val = unit_base[int'(unit_reg)*AW +: AW];
	assign base_used = !alloc_auto && unit_base_set[unit_reg];
	assign base_low = ({1'b0, base_val} < next_addr_reg);
	assign cost_total = 8'(cost_in + cost_out);
	assign slot_end = (AW+2)'(next_addr_reg) + (AW+2)'(cost_total);

	iora_slot_cost u_cost (
		.slot_type(eff_type),
		.wexp(eff_wexp),
		.in_cnt(cost_in),
		.out_cnt(cost_out),
		.legal(cost_legal)
	);

	// Allocation walk over units and slots
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			as_reg <= iora_pkg::iora_a_idle;
			unit_reg <= '0;
			slot_reg <= '0;
			next_addr_reg <= '0;
			word_cnt_reg <= 8'h00;
			total_reg <= 8'h00;
			in_cnt_reg <= 8'h00;
			cur_type_reg <= iora_pkg::iora_none;
		end else begin
			case (as_reg)
				iora_pkg::iora_a_idle: begin
					if (alloc_start) begin
						unit_reg <= '0;
						slot_reg <= '0;
						next_addr_reg <= '0;
						as_reg <= iora_pkg::iora_a_unit;
					end
				end
				iora_pkg::iora_a_unit: begin
					slot_reg <= '0;
					if (base_used && base_low) begin
						as_reg <= iora_pkg::iora_a_err;
					end else if (base_used) begin
						next_addr_reg <= {1'b0, base_val};
						as_reg <= iora_pkg::iora_a_slot;
					end else begin
						as_reg <= iora_pkg::iora_a_slot;
					end
				end
				iora_pkg::iora_a_slot: begin
					cur_type_reg <= eff_type;
					in_cnt_reg <= cost_in;
					total_reg <= cost_total;
					word_cnt_reg <= 8'h00;
					if (!cost_legal || (slot_end > (AW+2)'(iora_pkg::IORA_IO_WORDS))) begin
						as_reg <= iora_pkg::iora_a_err;
					end else if (cost_total != 8'h00) begin
						as_reg <= iora_pkg::iora_a_word;
					end else begin
						as_reg <= iora_pkg::iora_a_next;
					end
				end
				iora_pkg::iora_a_word: begin
					next_addr_reg <= next_addr_reg + (AW+1)'(1);
					word_cnt_reg <= word_cnt_reg + 8'h01;
					if (word_cnt_reg == total_reg - 8'h01) begin
						as_reg <= iora_pkg::iora_a_next;
					end
				end
				iora_pkg::iora_a_next: begin
					if (slot_reg == SW'(NS-1)) begin
						if (unit_reg == UW'(NU-1)) begin
							as_reg <= iora_pkg::iora_a_done;
						end else begin
							unit_reg <= unit_reg + UW'(1);
							as_reg <= iora_pkg::iora_a_unit;
						end
					end else begin
						slot_reg <= slot_reg + SW'(1);
						as_reg <= iora_pkg::iora_a_slot;
					end
				end
				default: as_reg <= iora_pkg::iora_a_idle;
			endcase
		end
	end

	// Error flags, cleared by the next start
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			alloc_error <= '0;
			alloc_err_slot <= '0;
		end else if (as_reg == iora_pkg::iora_a_idle && alloc_start) begin
			alloc_error <= '0;
		end else if (as_reg == iora_pkg::iora_a_unit && base_used && base_low) begin
			alloc_error[iora_pkg::IORA_ERR_BASE_LOW] <= 1'b1;
			alloc_err_slot <= IW'(int'(unit_reg) * NS); // Unit's slot 0, slot_reg is stale here
		end else if (as_reg == iora_pkg::iora_a_slot) begin
			if (!cost_legal) begin
				alloc_error[iora_pkg::IORA_ERR_BAD_TYPE] <= 1'b1;
				alloc_err_slot <= idx;
			end else if (slot_end > (AW+2)'(iora_pkg::IORA_IO_WORDS)) begin
				alloc_error[iora_pkg::IORA_ERR_OVERFLOW] <= 1'b1;
				alloc_err_slot <= idx;
			end
		end
	end

	// Done pulse and busy level
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			alloc_done <= 1'b0;
		end else begin
			alloc_done <= (as_reg == iora_pkg::iora_a_done);
		end
	end
	assign alloc_busy = (as_reg != iora_pkg::iora_a_idle);

	// Input word map; anything not marked is an output word
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_map_reg <= '0;
		end else if (as_reg == iora_pkg::iora_a_idle && alloc_start) begin
			in_map_reg <= '0;
		end else if (as_reg == iora_pkg::iora_a_word) begin
			in_map_reg[next_addr_reg[AW-1:0]] <= (word_cnt_reg < in_cnt_reg);
		end
	end

	// Per-slot result table
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NSLOT; i++) begin
				first_mem[i] <= '0;
				inc_mem[i] <= 8'h00;
				outc_mem[i] <= 8'h00;
			end
		end else if (as_reg == iora_pkg::iora_a_slot) begin
			first_mem[idx] <= next_addr_reg[AW-1:0];
			inc_mem[idx] <= cost_in;
			outc_mem[idx] <= cost_out;
		end
	end

	// Registered lookups
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			qry_first <= '0;
			qry_in_cnt <= 8'h00;
			qry_out_cnt <= 8'h00;
			word_is_input <= 1'b0;
		end else begin
			if (int'(qry_slot) < NSLOT) begin
				qry_first <= first_mem[qry_slot];
				qry_in_cnt <= inc_mem[qry_slot];
				qry_out_cnt <= outc_mem[qry_slot];
			end else begin
				qry_first <= '0;
				qry_in_cnt <= 8'h00;
				qry_out_cnt <= 8'h00;
			end
			word_is_input <= in_map_reg[word_addr];
		end
	end

	// Link transfer side
	iora_pkg::iora_xfer_t xs_reg;
	logic [9:0] lat_addr_reg;
	logic [1:0] rd_mask_reg;
	logic bridge_reg;
	logic rx_ch_reg;
	logic [BLK_W-1:0] blk;
	iora_pkg::iora_blk_t mode_c [2];
	logic [1:0] sending;
	logic [1:0] link_ch;
	logic is_bridge;
	logic [1:0] ctl_we;
	logic [9:0] ctl_addr;
	logic [DW-1:0] ctl_wdata [2];
	logic [DW-1:0] ctl_rdata [2];

	// Block and direction decode; index 0 is channel_one
	assign blk = xfer_addr[9 -: BLK_W];
	assign mode_c[0] = iora_pkg::iora_blk_t'(blk_mode_ch1[int'(blk)*2 +: 2]);
	assign mode_c[1] = iora_pkg::iora_blk_t'(blk_mode_ch2[int'(blk)*2 +: 2]);
	assign sending[0] = (xfer_addr >= send_lo_ch1) && (xfer_addr <= send_hi_ch1);
	assign sending[1] = (xfer_addr >= send_lo_ch2) && (xfer_addr <= send_hi_ch2);
	assign link_ch[0] = (mode_c[0] == iora_pkg::iora_blk_link) && chan_fitted[0];
	assign link_ch[1] = (mode_c[1] == iora_pkg::iora_blk_link) && chan_fitted[1];
	assign is_bridge = (mode_c[0] == iora_pkg::iora_blk_bridge) ||
		(mode_c[1] == iora_pkg::iora_blk_bridge);
	assign xfer_ready = (xs_reg == iora_pkg::iora_x_idle);
	assign ctl_addr = xfer_ready ? xfer_addr : lat_addr_reg;

	// Scan memory per channel, controller writes and bridge copies
	for (genvar c = 0; c < iora_pkg::IORA_CHANNELS; c++) begin : g_chan
		assign ctl_we[c] = (xfer_ready && xfer_req && !is_bridge && link_ch[c] && sending[c]) ||
			(!xfer_ready && bridge_reg && (rx_ch_reg != 1'(c)));
		assign ctl_wdata[c] = bridge_reg ? ctl_rdata[rx_ch_reg] : xfer_wdata;
		iora_scan_mem #(
			.DEPTH(iora_pkg::IORA_SCAN_WORDS),
			.DW(DW)
		) u_mem (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.ctl_we(ctl_we[c]),
			.ctl_addr(ctl_addr),
			.ctl_wdata(ctl_wdata[c]),
			.ctl_rdata(ctl_rdata[c]),
			.net_we(net_we[c]),
			.net_addr(net_addr[c*10 +: 10]),
			.net_wdata(net_wdata[c*DW +: DW]),
			.net_rdata(net_rdata[c*DW +: DW])
		);
	end

	// Transfer sequencing
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			xs_reg <= iora_pkg::iora_x_idle;
			lat_addr_reg <= 10'h000;
			rd_mask_reg <= 2'h0;
			bridge_reg <= 1'b0;
			rx_ch_reg <= 1'b0;
			xfer_done <= 1'b0;
			xfer_rd_valid <= 1'b0;
			xfer_rdata <= '0;
			xfer_cfg_err <= 1'b0;
		end else begin
			xfer_done <= 1'b0;
			xfer_rd_valid <= 1'b0;
			xfer_cfg_err <= 1'b0;
			case (xs_reg)
				iora_pkg::iora_x_idle: begin
					bridge_reg <= 1'b0;
					if (xfer_req) begin
						lat_addr_reg <= xfer_addr;
						if (is_bridge && chan_fitted != 2'h3) begin
							xfer_cfg_err <= 1'b1;
							xfer_done <= 1'b1;
						end else if (is_bridge) begin
							bridge_reg <= 1'b1;
							rx_ch_reg <= sending[0];
							xs_reg <= iora_pkg::iora_x_read;
						end else if ((link_ch & ~sending) != 2'h0) begin
							rd_mask_reg <= link_ch & ~sending;
							xs_reg <= iora_pkg::iora_x_read;
						end else begin
							xfer_done <= 1'b1;
						end
					end
				end
				iora_pkg::iora_x_read: begin
					xfer_done <= 1'b1;
					xfer_rd_valid <= 1'b1;
					bridge_reg <= 1'b0; // Keep a following send from copying stale data
					if (bridge_reg) begin
						xfer_rdata <= ctl_rdata[rx_ch_reg];
					end else begin
						xfer_rdata <= rd_mask_reg[0] ? ctl_rdata[0] : ctl_rdata[1];
					end
					xs_reg <= iora_pkg::iora_x_idle;
				end
				default: xs_reg <= iora_pkg::iora_x_idle;
			endcase
		end
	end

	// Checks on the allocation walk and transfers
	AST_BASE_PLACE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_unit && base_used && !base_low
		|=> next_addr_reg == {1'b0, $past(base_val)} && as_reg == iora_pkg::iora_a_slot)
		else $error("unit base not applied");
	AST_BASE_REJECT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_unit && base_used && base_low
		|=> alloc_error[iora_pkg::IORA_ERR_BASE_LOW] ##1 !alloc_busy)
		else $error("low unit base not rejected");
	AST_ASCEND: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_word |=> next_addr_reg == $past(next_addr_reg) + (AW+1)'(1))
		else $error("word address did not ascend by one");
	AST_CONTINUE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_unit && !base_used |=> $stable(next_addr_reg))
		else $error("unit without base did not continue");
	AST_EMPTY_SLOT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_slot && eff_type == iora_pkg::iora_none
		|=> as_reg == iora_pkg::iora_a_next ##1 next_addr_reg == $past(next_addr_reg, 2))
		else $error("empty slot consumed words");
	AST_HALF_RACK: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_slot && half_rack[unit_reg] && int'(slot_reg) >= HALF_SLOTS
		|=> as_reg != iora_pkg::iora_a_word)
		else $error("half rack trailing slot consumed words");
	AST_SPACER_OUT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_word && cur_type_reg == iora_pkg::iora_spacer_slot_type
		|=> !in_map_reg[$past(next_addr_reg[AW-1:0])])
		else $error("spacer word marked as input");
	AST_NO_IO_TYPES: assert property (@(posedge sys_clk) disable iff (!arst_n)
		as_reg == iora_pkg::iora_a_slot && eff_type inside {iora_pkg::iora_unused_z_type,
		iora_pkg::iora_memory_card_slot_type, iora_pkg::iora_scan_network_slot_type,
		iora_pkg::iora_fast_network_slot_type} |=> as_reg != iora_pkg::iora_a_word)
		else $error("non-I/O type consumed words");
	AST_BLANK: assert property (@(posedge sys_clk) disable iff (!arst_n)
		xfer_ready && xfer_req && mode_c[0] == iora_pkg::iora_blk_blank &&
		mode_c[1] == iora_pkg::iora_blk_blank
		|-> ctl_we == 2'h0 ##1 xfer_done && !xfer_rd_valid && xfer_ready)
		else $error("blank block made a transfer");
	AST_BRIDGE_CFG: assert property (@(posedge sys_clk) disable iff (!arst_n)
		xfer_ready && xfer_req && is_bridge && chan_fitted != 2'h3
		|-> ctl_we == 2'h0 ##1 xfer_cfg_err && xfer_done)
		else $error("bridge accepted without two channels");
	AST_BRIDGE_COPY: assert property (@(posedge sys_clk) disable iff (!arst_n)
		xs_reg == iora_pkg::iora_x_read && bridge_reg
		|-> ctl_we[!rx_ch_reg] && ctl_wdata[!rx_ch_reg] == ctl_rdata[rx_ch_reg]
		##1 xfer_rdata == $past(ctl_rdata[rx_ch_reg]) && xfer_rd_valid)
		else $error("bridge copy mismatch");

endmodule : iora_allocator

//--- tb/iora_net_model.sv
/*
 * Network side of two channels: writes and reads scan words by port.
 * Assumes scan memories with registered read data, one cycle late.
 */
`timescale 1ns/10ps
module iora_net_model (
	input wire logic sys_clk,
	output logic [1:0] net_we,
	output logic [19:0] net_addr,
	output logic [31:0] net_wdata,
	input wire logic [31:0] net_rdata
);
	// Idle at time zero
	initial begin
		net_we = 2'h0;
		net_addr = 20'h0;
		net_wdata = 32'h0;
	end
	// Write one word, then let the data line wander
	task put(input int c, input logic [9:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		net_we[c] <= 1'b1;
		net_addr[c*10+:10] <= a;
		net_wdata[c*16+:16] <= d;
		@(posedge sys_clk);
		net_we[c] <= 1'b0;
		net_wdata[c*16+:16] <= ~d;
	endtask : put
	// Read one word, registered
	task get(input int c, input logic [9:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		net_addr[c*10+:10] <= a;
		@(posedge sys_clk);
		#1 d = net_rdata[c*16+:16];
	endtask : get
endmodule : iora_net_model

//--- tb/tb_iora_allocator.sv
/*
 * Bench: register placement walk and link block transfers.
 * Assumes default sizes: 4 units of 11 slots, 10-bit word addresses.
 */
`timescale 1ns/10ps
module tb_iora_allocator;
	logic sys_clk = 0, arst_n = 0, alloc_start = 0, alloc_auto = 0, xfer_req = 0;
	logic [3:0] unit_base_set = 4'h2, half_rack = 4'h4;
	logic [39:0] unit_base = 40'h0;
	logic [175:0] slot_type = '0;
	logic [131:0] slot_wexp = '0;
	logic [5:0] qry_slot = 6'h0;
	logic [9:0] word_addr = 10'h0, xfer_addr = 10'h0;
	logic [1:0] chan_fitted = 2'h1, net_we;
	logic [31:0] blk_mode_ch1 = 32'h80000001, blk_mode_ch2 = 32'h80000000;
	logic [9:0] send_lo_ch1 = 10'h0, send_hi_ch1 = 10'h9, send_lo_ch2 = 10'h3c0;
	logic [9:0] send_hi_ch2 = 10'h3ff, qry_first;
	logic [15:0] xfer_wdata = 16'h0, xfer_rdata, v;
	logic alloc_busy, alloc_done, word_is_input, xfer_ready, xfer_done, xfer_rd_valid;
	logic xfer_cfg_err, dn, rv, ce;
	logic [2:0] alloc_error;
	logic [3:0] e;
	logic [5:0] alloc_err_slot;
	logic [7:0] qry_in_cnt, qry_out_cnt;
	logic [19:0] net_addr;
	logic [31:0] net_wdata, net_rdata;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	iora_allocator dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .alloc_start(alloc_start),
		.alloc_auto(alloc_auto), .unit_base_set(unit_base_set), .unit_base(unit_base),
		.half_rack(half_rack), .slot_type(slot_type), .slot_wexp(slot_wexp),
		.alloc_busy(alloc_busy), .alloc_done(alloc_done), .alloc_error(alloc_error),
		.alloc_err_slot(alloc_err_slot), .qry_slot(qry_slot), .qry_first(qry_first),
		.qry_in_cnt(qry_in_cnt), .qry_out_cnt(qry_out_cnt), .word_addr(word_addr),
		.word_is_input(word_is_input), .chan_fitted(chan_fitted),
		.blk_mode_ch1(blk_mode_ch1), .blk_mode_ch2(blk_mode_ch2),
		.send_lo_ch1(send_lo_ch1), .send_hi_ch1(send_hi_ch1), .send_lo_ch2(send_lo_ch2),
		.send_hi_ch2(send_hi_ch2), .xfer_req(xfer_req), .xfer_addr(xfer_addr),
		.xfer_wdata(xfer_wdata), .xfer_ready(xfer_ready), .xfer_done(xfer_done),
		.xfer_rd_valid(xfer_rd_valid), .xfer_rdata(xfer_rdata), .xfer_cfg_err(xfer_cfg_err),
		.net_we(net_we), .net_addr(net_addr), .net_wdata(net_wdata), .net_rdata(net_rdata));
	iora_net_model net_u (.sys_clk(sys_clk), .net_we(net_we), .net_addr(net_addr),
		.net_wdata(net_wdata), .net_rdata(net_rdata));
	// Clock and hang limit
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task chk(input string w, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", w, exp, got);
		end
	endtask : chk
	task slot(input int i, input iora_pkg::iora_slot_t t, input logic [2:0] x);
		slot_type[i*4+:4] <= t;
		slot_wexp[i*3+:3] <= x;
	endtask : slot
	// One walk; returns done above the error flags
	task walk(output logic [3:0] err);
		@(posedge sys_clk) alloc_start <= 1'b1;
		@(posedge sys_clk) alloc_start <= 1'b0;
		for (int k = 0; k < 500; k++) begin
			#1;
			if (alloc_done === 1'b1 || alloc_error !== 3'h0) break;
			@(posedge sys_clk);
		end
		err = {alloc_done, alloc_error};
	endtask : walk
	task qry(input int i, input int f, input int ni, input int no);
		@(posedge sys_clk) qry_slot <= 6'(i);
		repeat (2) @(posedge sys_clk);
		#1;
		if (f >= 0) chk("first", qry_first, f);
		chk("in", qry_in_cnt, ni);
		chk("out", qry_out_cnt, no);
	endtask : qry
	task word(input int a, input logic x);
		@(posedge sys_clk) word_addr <= 10'(a);
		repeat (2) @(posedge sys_clk);
		#1 chk("is_input", word_is_input, x);
	endtask : word
	task s_place;
		@(posedge sys_clk);
		slot(0, iora_pkg::iora_input, 3'h1);
		slot(2, iora_pkg::iora_spacer_slot_type, 3'h2);
		slot(3, iora_pkg::iora_mixed, 3'h1);
		slot(4, iora_pkg::iora_memory_card_slot_type, 3'h0);
		slot(5, iora_pkg::iora_scan_network_slot_type, 3'h0);
		slot(11, iora_pkg::iora_output, 3'h0);
		slot(22, iora_pkg::iora_input, 3'h3);
		slot(29, iora_pkg::iora_input, 3'h0);
		unit_base[19:10] <= 10'h14;
		walk(e);
		chk("done", e, 4'h8);
		chk("busy", alloc_busy, 1'b0);
		qry(0, 0, 2, 0);
		qry(2, 2, 0, 4);
		qry(3, 6, 1, 1);
		qry(1, -1, 0, 0);
		qry(4, -1, 0, 0);
		qry(5, -1, 0, 0);
		qry(11, 20, 0, 1);
		qry(22, 21, 8, 0);
		qry(29, -1, 0, 0);
		word(6, 1'b1);
		word(7, 1'b0);
		word(28, 1'b1);
		word(100, 1'b0);
	endtask : s_place
	task s_base_low;
		@(posedge sys_clk) begin
			unit_base[19:10] <= 10'h3;
			alloc_auto <= 1'b1;
		end
		walk(e);
		chk("auto", e, 4'h8);
		qry(11, 8, 0, 1);
		@(posedge sys_clk) alloc_auto <= 1'b0;
		walk(e);
		chk("err", e, 4'h1);
		chk("err_slot", alloc_err_slot, 11);
		@(posedge sys_clk) slot(1, iora_pkg::iora_input, 3'h6);
		walk(e);
		chk("bad_type", e, 4'h4);
		chk("bad_slot", alloc_err_slot, 1);
	endtask : s_base_low
	task xf(input int a, input logic [15:0] d);
		@(posedge sys_clk) begin
			xfer_req <= 1'b1;
			xfer_addr <= 10'(a);
			xfer_wdata <= d;
		end
		@(posedge sys_clk) xfer_req <= 1'b0;
		dn = 0;
		for (int k = 0; k < 4 && !dn; k++) begin
			#1 {dn, rv, ce} = {xfer_done, xfer_rd_valid, xfer_cfg_err};
			if (!dn) @(posedge sys_clk);
		end
		chk("xfer_done", dn, 1'b1);
	endtask : xf
	task s_link;
		net_u.put(0, 10'hc, 16'h5a3c);
		xf(12, 16'h0);
		chk("rd_valid", rv, 1'b1);
		chk("rdata", xfer_rdata, 16'h5a3c);
		xf(5, 16'h1234);
		net_u.get(0, 10'h5, v);
		chk("sent", v, 16'h1234);
		xf(100, 16'h0);
		chk("blank_rd", rv, 1'b0);
		xf(970, 16'h0);
		chk("cfg_err", ce, 1'b1);
		@(posedge sys_clk) chan_fitted <= 2'h3;
		net_u.put(0, 10'h3ca, 16'hbeef);
		xf(970, 16'h0);
		chk("bridge_rd", xfer_rdata, 16'hbeef);
		net_u.get(1, 10'h3ca, v);
		chk("bridge_copy", v, 16'hbeef);
	endtask : s_link
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		chk("rst_ready", xfer_ready, 1'b1);
		arst_n <= 1'b1;
		s_place();
		s_base_low();
		s_link();
		stop_test();
	end
endmodule : tb_iora_allocator
